/* core/cke_pwr_pkg.sv */
// Shared types and constants for the clock-enable power-state logic
package cke_pwr_pkg;

   // Power states, one-hot
   typedef enum logic [3:0] {
      ST_ACT = 4'h1,
      ST_APD = 4'h2,
      ST_PPD = 4'h4,
      ST_SR  = 4'h8
   } pwr_state_t;

   // Command pins sampled at a clock edge
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } cmd_pins_t;

   // Status levels handed to the system clock domain
   typedef struct packed {
      logic pd_active;
      logic pd_precharge;
      logic sr_active;
      logic read_ok;
      logic term_on;
      logic illegal;
   } status_t;

   localparam int STAT_W = $bits(status_t);

   // Command codes on ras_n, cas_n, we_n
   localparam logic [2:0] CMD_NOP = 3'h7;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_LM = 3'h0;

   localparam int ADDR_W = 13;
   localparam int BANKS = 4;
   localparam int A10_POS = 10;
   localparam logic [1:0] BA_MR = 2'h0;

   // Mode register fields
   localparam int MR_BL_LSB = 0;
   localparam int MR_CL_LSB = 4;
   localparam int MR_WR_LSB = 9;
   localparam int MR_PD_SLOW = 12;
   localparam logic [ADDR_W-1:0] MR_RESET = 13'h0000;

   // Timing in clock cycles of the link clock
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CKE_MIN_CK = 8'h03;
   localparam logic [CNT_W-1:0] XSRD_CK = 8'hc8;
   localparam logic [CNT_W-1:0] MRD_CK = 8'h02;
   localparam logic [CNT_W-1:0] PRE_BUSY_CK = 8'h01;
   localparam logic [2:0] BL8_CODE = 3'h3;
   localparam logic [CNT_W-1:0] BL4_HALF = 8'h02;
   localparam logic [CNT_W-1:0] BL8_HALF = 8'h04;

   // Deselect or NOP
   function automatic logic is_nop(input cmd_pins_t c);
      return c.cs_n || ({c.ras_n, c.cas_n, c.we_n} == CMD_NOP);
   endfunction

   // True when the pins carry the given command with chip select low
   function automatic logic is_cmd(input cmd_pins_t c, input logic [2:0] code);
      return !c.cs_n && ({c.ras_n, c.cas_n, c.we_n} == code);
   endfunction

endpackage

/* core/rst_sync.sv */
// Reset synchroniser: asynchronous assert, synchronous release
`timescale 1ns/1ps
module rst_sync (
   input wire logic clk_i,
   input wire logic rstn_i,
   output logic rstn_o
);
   logic stage;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         stage <= 1'b0;
         rstn_o <= 1'b0;
      end else begin
         stage <= 1'b1;
         rstn_o <= stage;
      end
   end
endmodule // rst_sync

/* core/level_sync.sv */
// Two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
module level_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule // level_sync

/* core/cke_pwr_ctrl.sv */
// Clock-enable power-state logic of the memory device
// Summary of operation
// RL1 - State action from previous/current CKE plus command
// RL2 - Both CKE samples low: hold state, ignore commands
// RL3 - Power-down entry/exit edges carry NOP/DESELECT only
// RL4 - Self refresh: REFRESH on CKE fall, banks idle
// RL5 - Self refresh exit edge carries NOP/DESELECT only
// RL6 - No READ for 200 clocks after exit
// RL7 - Idle banks give precharge, open rows active power-down
// RL8 - No entry during read/write/load/precharge operation
// RL9 - CKE level held three registering edges minimum
// RL10 - No refresh during power-down; controller bounds duration
// RL11 - Termination ignored by states; off in self refresh
// RL12 - Unlisted state/CKE/command combinations are illegal
// RL13 - Read: entry from edge after burst ends
// RL14 - Write: entry after burst fully completes
// RL15 - Write auto precharge after WR count expires
// RL16 - WR count held in mode bits 9-11
// RL17 - Entry one clock after REFRESH/ACTIVATE/PRECHARGE
// RL18 - Load mode needs idle banks, then mode delay
// RL19 - Clock change only in precharge power-down
// RL20 - Termination and CKE low through clock change
// RL21 - Stable new clock before leaving power-down
// RL22 - DLL reset and mode update after clock change
// RL23 - Termination off through 200-cycle relock
// RL24 - Active power-down exit speed from mode bit 12; the logic latches bit 12 but uses it for no exit timing
// RL25 - Controller tracks banks and bursts for entry
`timescale 1ns/1ps
module cke_pwr_ctrl
   import cke_pwr_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic mem_ck_i,
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [1:0] ba_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic odt_i,
   output logic pd_active_o,
   output logic pd_precharge_o,
   output logic sr_active_o,
   output logic read_ok_o,
   output logic term_on_o,
   output logic illegal_o
);
   logic ck_rstn;
   cmd_pins_t cmd;
   pwr_state_t state;
   pwr_state_t next_state;
   logic cke_prev;
   logic [CNT_W-1:0] cke_run;
   logic [BANKS-1:0] bank_open;
   logic [CNT_W-1:0] busy_cnt;
   logic [CNT_W-1:0] ap_cnt;
   logic [1:0] ap_bank;
   logic ap_pend;
   logic [CNT_W-1:0] xsrd_cnt;
   logic [ADDR_W-1:0] mode_reg;
   logic illegal;
   logic term_on;
   logic bad_now;
   logic fall;
   logic rise;
   logic live;
   logic [CNT_W-1:0] burst_half;
   logic [CNT_W-1:0] cas_lat;
   logic [CNT_W-1:0] wr_rec;
   status_t stat_ck;
   status_t stat_sys;

   assign cmd = '{cs_n: cs_n_i, ras_n: ras_n_i, cas_n: cas_n_i, we_n: we_n_i};
   // RL1 edge classification
   assign fall = cke_prev && !cke_i;
   assign rise = !cke_prev && cke_i;
   assign live = cke_prev && cke_i;

   // RL16 write recovery from mode bits
   assign wr_rec = CNT_W'(mode_reg[MR_WR_LSB +: 3]) + CNT_W'(1);
   assign cas_lat = CNT_W'(mode_reg[MR_CL_LSB +: 3]);
   assign burst_half = (mode_reg[MR_BL_LSB +: 3] == BL8_CODE) ? BL8_HALF : BL4_HALF;

   rst_sync u_ck_rst (
      .clk_i(mem_ck_i),
      .rstn_i(rstn_i),
      .rstn_o(ck_rstn)
   );

   // Reset high so a clock-enable already high at release is no false rise
   always_ff @(posedge mem_ck_i or negedge ck_rstn) begin
      if (!ck_rstn) begin
         cke_prev <= 1'b1;
      end else begin
         cke_prev <= cke_i;
      end
   end

   // RL9 consecutive registrations at one level
   always_ff @(posedge mem_ck_i or negedge ck_rstn) begin
      if (!ck_rstn) begin
         cke_run <= CKE_MIN_CK;
      end else if (cke_i != cke_prev) begin
         cke_run <= CNT_W'(1);
      end else if (cke_run < CKE_MIN_CK) begin
         cke_run <= cke_run + CNT_W'(1);
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         ST_ACT: begin
            // RL4 self refresh entry from idle banks
            if (fall && is_cmd(cmd, CMD_REF) && bank_open == '0) begin
               next_state = ST_SR;
            // RL7 power-down type by bank state
            end else if (fall && is_nop(cmd)) begin
               next_state = (bank_open == '0) ? ST_PPD : ST_APD;
            end
         end
         ST_APD, ST_PPD, ST_SR: begin
            // RL2 hold while both samples low
            if (rise) begin
               next_state = ST_ACT;
            end
         end
         default: next_state = ST_ACT;
      endcase
   end

   always_ff @(posedge mem_ck_i or negedge ck_rstn) begin
      if (!ck_rstn) begin
         state <= ST_ACT;
      end else begin
         state <= next_state;
      end
   end

   // RL12 illegal sequence detection
   always_comb begin
      bad_now = 1'b0;
      // RL3 entry and exit commands
      if ((fall || rise) && !is_nop(cmd) && !(fall && is_cmd(cmd, CMD_REF))) begin
         bad_now = 1'b1;
      end
      // RL4 refresh entry with open rows
      if (fall && is_cmd(cmd, CMD_REF) && bank_open != '0) begin
         bad_now = 1'b1;
      end
      // RL9 short CKE level
      if ((fall || rise) && cke_run < CKE_MIN_CK) begin
         bad_now = 1'b1;
      end
      // RL8 entry during an operation
      if (fall && busy_cnt != '0) begin
         bad_now = 1'b1;
      end
      // RL6 read before relock
      if (live && is_cmd(cmd, CMD_RD) && xsrd_cnt != '0) begin
         bad_now = 1'b1;
      end
      // RL18 load mode with rows open
      if (live && is_cmd(cmd, CMD_LM) && bank_open != '0) begin
         bad_now = 1'b1;
      end
      if (state == ST_ACT && !cke_prev && cke_i) begin
         bad_now = 1'b1;
      end
   end

   // Sticky until reset; no software clear path exists
   always_ff @(posedge mem_ck_i or negedge ck_rstn) begin
      if (!ck_rstn) begin
         illegal <= 1'b0;
      end else if (bad_now) begin
         illegal <= 1'b1;
      end
   end

   // RL16 mode register latch
   always_ff @(posedge mem_ck_i or negedge ck_rstn) begin
      if (!ck_rstn) begin
         mode_reg <= MR_RESET;
      end else if (live && is_cmd(cmd, CMD_LM) && ba_i == BA_MR) begin
         mode_reg <= addr_i;
      end
   end

   // RL13 RL14 RL17 RL18 operation in progress
   always_ff @(posedge mem_ck_i or negedge ck_rstn) begin
      if (!ck_rstn) begin
         busy_cnt <= '0;
      end else if (live && is_cmd(cmd, CMD_RD)) begin
         busy_cnt <= cas_lat + burst_half;
      end else if (live && is_cmd(cmd, CMD_WR)) begin
         busy_cnt <= cas_lat - CNT_W'(1) + burst_half + wr_rec;
      // Count holds refused edges; entry is legal on the edge after it ends
      end else if (live && is_cmd(cmd, CMD_LM)) begin
         busy_cnt <= MRD_CK - CNT_W'(1);
      end else if (live && is_cmd(cmd, CMD_PRE)) begin
         busy_cnt <= PRE_BUSY_CK - CNT_W'(1);
      end else if (busy_cnt != '0) begin
         busy_cnt <= busy_cnt - CNT_W'(1);
      end
   end

   // RL15 auto precharge timer, one pending at a time
   always_ff @(posedge mem_ck_i or negedge ck_rstn) begin
      if (!ck_rstn) begin
         ap_pend <= 1'b0;
         ap_cnt <= '0;
         ap_bank <= '0;
      end else if (live && addr_i[A10_POS] && is_cmd(cmd, CMD_WR)) begin
         ap_pend <= 1'b1;
         ap_cnt <= cas_lat - CNT_W'(1) + burst_half + wr_rec;
         ap_bank <= ba_i;
      end else if (live && addr_i[A10_POS] && is_cmd(cmd, CMD_RD)) begin
         ap_pend <= 1'b1;
         ap_cnt <= cas_lat + burst_half;
         ap_bank <= ba_i;
      end else if (ap_pend && ap_cnt != '0) begin
         ap_cnt <= ap_cnt - CNT_W'(1);
      end else begin
         ap_pend <= 1'b0;
      end
   end

   // RL25 bank open tracking
   always_ff @(posedge mem_ck_i or negedge ck_rstn) begin
      if (!ck_rstn) begin
         bank_open <= '0;
      end else if (live && is_cmd(cmd, CMD_ACT)) begin
         bank_open[ba_i] <= 1'b1;
      end else if (live && is_cmd(cmd, CMD_PRE)) begin
         if (addr_i[A10_POS]) begin
            bank_open <= '0;
         end else begin
            bank_open[ba_i] <= 1'b0;
         end
      end else if (ap_pend && ap_cnt == '0) begin
         bank_open[ap_bank] <= 1'b0;
      end
   end

   // RL6 read lockout after self refresh exit
   always_ff @(posedge mem_ck_i or negedge ck_rstn) begin
      if (!ck_rstn) begin
         xsrd_cnt <= '0;
      end else if (state == ST_SR && rise) begin
         xsrd_cnt <= XSRD_CK;
      end else if (xsrd_cnt != '0) begin
         xsrd_cnt <= xsrd_cnt - CNT_W'(1);
      end
   end

   // RL11 termination follows the pin except in self refresh
   always_ff @(posedge mem_ck_i or negedge ck_rstn) begin
      if (!ck_rstn) begin
         term_on <= 1'b0;
      end else begin
         term_on <= odt_i && next_state != ST_SR;
      end
   end

   // Each bit crosses on its own; they are not coherent as a word
   assign stat_ck = '{
      pd_active: state == ST_APD || state == ST_PPD,
      pd_precharge: state == ST_PPD,
      sr_active: state == ST_SR,
      read_ok: xsrd_cnt == '0,
      term_on: term_on,
      illegal: illegal
   };

   level_sync #(.W(STAT_W)) u_stat_sync (
      .clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .d_i(stat_ck),
      .q_o(stat_sys)
   );

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pd_active_o <= 1'b0;
         pd_precharge_o <= 1'b0;
         sr_active_o <= 1'b0;
         read_ok_o <= 1'b0;
         term_on_o <= 1'b0;
         illegal_o <= 1'b0;
      end else begin
         pd_active_o <= stat_sys.pd_active;
         pd_precharge_o <= stat_sys.pd_precharge;
         sr_active_o <= stat_sys.sr_active;
         read_ok_o <= stat_sys.read_ok;
         term_on_o <= stat_sys.term_on;
         illegal_o <= stat_sys.illegal;
      end
   end

   default clocking cb @(posedge mem_ck_i);
   endclocking
   default disable iff (!ck_rstn);

   property p_hold_low;
      (state != ST_ACT && !cke_prev && !cke_i) |=> (state == $past(state));
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("state left with CKE low"); // RL2

   property p_live_stays;
      (state == ST_ACT && live) |=> (state == ST_ACT);
   endproperty
   a_live_stays: assert property (p_live_stays) else $error("state moved, CKE high"); // RL1

   property p_ppd_entry;
      (state == ST_ACT && fall && is_nop(cmd) && bank_open == '0) |=> (state == ST_PPD);
   endproperty
   a_ppd_entry: assert property (p_ppd_entry) else $error("no precharge power-down"); // RL7

   property p_apd_entry;
      (state == ST_ACT && fall && is_nop(cmd) && bank_open != '0) |=> (state == ST_APD);
   endproperty
   a_apd_entry: assert property (p_apd_entry) else $error("no active power-down"); // RL7

   property p_sr_entry;
      (state == ST_ACT && fall && is_cmd(cmd, CMD_REF) && bank_open == '0) |=> (state == ST_SR);
   endproperty
   a_sr_entry: assert property (p_sr_entry) else $error("no self refresh entry"); // RL4

   property p_xsrd;
      (state == ST_SR && rise) |=> (xsrd_cnt == XSRD_CK) ##1 (xsrd_cnt == XSRD_CK - 8'h01);
   endproperty
   a_xsrd: assert property (p_xsrd) else $error("read lockout not started"); // RL6

   property p_short_cke;
      ((fall || rise) && cke_run < CKE_MIN_CK) |=> illegal;
   endproperty
   a_short_cke: assert property (p_short_cke) else $error("short CKE not flagged"); // RL9

   property p_term_sr;
      (state == ST_SR && !rise) |=> !term_on;
   endproperty
   a_term_sr: assert property (p_term_sr) else $error("termination in self refresh"); // RL11

   property p_ap_close;
      (ap_pend && ap_cnt == '0 && !live) |=> !bank_open[$past(ap_bank)];
   endproperty
   a_ap_close: assert property (p_ap_close) else $error("auto precharge missed"); // RL15

   c_ppd_cycle: cover property (state == ST_ACT ##1 state == ST_PPD ##[1:20] state == ST_ACT);
   c_apd_cycle: cover property (state == ST_APD ##[1:20] state == ST_ACT);
   c_sr_exit: cover property (state == ST_SR ##1 state == ST_ACT ##[1:10] xsrd_cnt != '0);

endmodule // cke_pwr_ctrl

/* dv/mem_ctrl_model.sv */
// Behavioural memory controller driving clock, clock-enable, commands and termination
`timescale 1ns/1ps
module mem_ctrl_model
   import cke_pwr_pkg::*;
(
   output logic mem_ck_o,
   output logic cke_o,
   output logic cs_n_o,
   output logic ras_n_o,
   output logic cas_n_o,
   output logic we_n_o,
   output logic [1:0] ba_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic odt_o
);
   logic odt_lvl = 1'b0;

   initial begin
      mem_ck_o = 1'b0;
      cke_o = 1'b0;
      cs_n_o = 1'b1;
      {ras_n_o, cas_n_o, we_n_o} = CMD_NOP;
      ba_o = 2'h0;
      addr_o = '0;
      odt_o = 1'b0;
   end

   // Free running, phase unrelated to the system clock
   initial begin
      #5.3;
      forever #16 mem_ck_o = ~mem_ck_o;
   end

   task automatic set_odt(input logic v);
      odt_lvl = v;
   endtask

   // legal order comes from the caller
   // termination always driven to a level
   task automatic cyc(input logic k, input logic [2:0] c, input logic [1:0] b,
                      input logic [ADDR_W-1:0] a);
      @(posedge mem_ck_o);
      #1;
      cke_o = k;
      cs_n_o = 1'b0;
      {ras_n_o, cas_n_o, we_n_o} = c;
      ba_o = b;
      addr_o = a;
      odt_o = odt_lvl;
   endtask

   // Deselected lines carry no value, so show the inverse of the last one
   task automatic desel(input logic k);
      @(posedge mem_ck_o);
      #1;
      cke_o = k;
      cs_n_o = 1'b1;
      {ras_n_o, cas_n_o, we_n_o} = ~{ras_n_o, cas_n_o, we_n_o};
      ba_o = ~ba_o;
      addr_o = ~addr_o;
      odt_o = odt_lvl;
   endtask
endmodule // mem_ctrl_model

/* dv/cke_pwr_ctrl_bench.sv */
// Self-checking bench for the clock-enable power-state logic
`timescale 1ns/1ps
module cke_pwr_ctrl_bench
   import cke_pwr_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic mem_ck, cke, cs_n, ras_n, cas_n, we_n, odt;
   logic [1:0] ba;
   logic [ADDR_W-1:0] addr;
   logic pd_active, pd_precharge, sr_active, read_ok, term_on, illegal;
   int fail_count = 0;
   int checked = 0;

   always #4 sys_clk = ~sys_clk;

   mem_ctrl_model u_ctrl (
      .mem_ck_o(mem_ck),
      .cke_o(cke),
      .cs_n_o(cs_n),
      .ras_n_o(ras_n),
      .cas_n_o(cas_n),
      .we_n_o(we_n),
      .ba_o(ba),
      .addr_o(addr),
      .odt_o(odt)
   );

   cke_pwr_ctrl u_dut (
      .sys_clk_i(sys_clk),
      .rstn_i(rstn),
      .mem_ck_i(mem_ck),
      .cke_i(cke),
      .cs_n_i(cs_n),
      .ras_n_i(ras_n),
      .cas_n_i(cas_n),
      .we_n_i(we_n),
      .ba_i(ba),
      .addr_i(addr),
      .odt_i(odt),
      .pd_active_o(pd_active),
      .pd_precharge_o(pd_precharge),
      .sr_active_o(sr_active),
      .read_ok_o(read_ok),
      .term_on_o(term_on),
      .illegal_o(illegal)
   );

   task automatic nop(input logic k, input int n);
      repeat (n) u_ctrl.cyc(k, CMD_NOP, 2'h0, '0);
   endtask

   task automatic chk(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         $display("mismatch %s expected %b seen %b", what, exp, got);
         fail_count++;
      end
   endtask

   // Clock-enable raised while still in reset so no false rise is seen
   task automatic do_reset();
      rstn = 1'b0;
      nop(1'b0, 2);
      nop(1'b1, 3);
      chk("pd_active", 1'b0, pd_active);
      chk("read_ok", 1'b0, read_ok);
      chk("illegal", 1'b0, illegal);
      rstn = 1'b1;
      nop(1'b1, 6);
      chk("read_ok", 1'b1, read_ok);
      chk("illegal", 1'b0, illegal);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // About 370 link clocks expected; generous margin
   initial begin
      #60000;
      fail_count++;
      $display("mismatch watchdog expected done seen hang");
      print_verdict();
   end

   initial begin
      do_reset();
      u_ctrl.set_odt(1'b1);
      nop(1'b1, 3);
      chk("term_on", 1'b1, term_on);
      u_ctrl.desel(1'b0);
      u_ctrl.cyc(1'b0, CMD_RD, 2'h1, 13'h0400);
      u_ctrl.cyc(1'b0, CMD_WR, 2'h2, 13'h0000);
      chk("pd_active", 1'b1, pd_active);
      chk("pd_precharge", 1'b1, pd_precharge);
      chk("term_on", 1'b1, term_on);
      chk("illegal", 1'b0, illegal);
      nop(1'b1, 3);
      chk("pd_active", 1'b0, pd_active);
      u_ctrl.cyc(1'b1, CMD_ACT, 2'h1, 13'h0000);
      nop(1'b0, 3);
      chk("pd_active", 1'b1, pd_active);
      chk("pd_precharge", 1'b0, pd_precharge);
      nop(1'b1, 3);
      u_ctrl.cyc(1'b1, CMD_PRE, 2'h0, 13'h0400);
      nop(1'b0, 3);
      chk("pd_precharge", 1'b1, pd_precharge);
      nop(1'b1, 3);
      u_ctrl.set_odt(1'b0);
      // BL8, CL3, WR2 mode
      u_ctrl.cyc(1'b1, CMD_LM, BA_MR, 13'h0233);
      nop(1'b1, 2);
      u_ctrl.cyc(1'b1, CMD_ACT, 2'h2, 13'h0000);
      u_ctrl.cyc(1'b1, CMD_RD, 2'h2, 13'h0000);
      nop(1'b1, 7);
      nop(1'b0, 3);
      chk("pd_active", 1'b1, pd_active);
      chk("pd_precharge", 1'b0, pd_precharge);
      chk("illegal", 1'b0, illegal);
      nop(1'b1, 3);
      u_ctrl.cyc(1'b1, CMD_WR, 2'h2, 13'h0400);
      nop(1'b1, 9);
      nop(1'b0, 3);
      chk("pd_active", 1'b1, pd_active);
      chk("pd_precharge", 1'b1, pd_precharge);
      chk("illegal", 1'b0, illegal);
      nop(1'b1, 3);
      u_ctrl.set_odt(1'b1);
      u_ctrl.cyc(1'b0, CMD_REF, 2'h0, 13'h0000);
      nop(1'b0, 2);
      chk("sr_active", 1'b1, sr_active);
      chk("pd_active", 1'b0, pd_active);
      chk("term_on", 1'b0, term_on);
      u_ctrl.set_odt(1'b0);
      u_ctrl.desel(1'b1);
      nop(1'b1, 2);
      chk("sr_active", 1'b0, sr_active);
      chk("read_ok", 1'b0, read_ok);
      nop(1'b1, 190);
      chk("read_ok", 1'b0, read_ok);
      nop(1'b1, 12);
      chk("read_ok", 1'b1, read_ok);
      u_ctrl.cyc(1'b1, CMD_ACT, 2'h0, 13'h0000);
      u_ctrl.cyc(1'b1, CMD_RD, 2'h0, 13'h0000);
      nop(1'b1, 2);
      chk("illegal", 1'b0, illegal);
      // Each breach is sticky, so reset between them
      for (int k = 0; k < 5; k++) begin
         do_reset();
         case (k)
            0: begin
               u_ctrl.cyc(1'b1, CMD_ACT, 2'h0, 13'h0000);
               u_ctrl.cyc(1'b1, CMD_RD, 2'h0, 13'h0000);
               nop(1'b0, 3);
            end
            1: begin
               nop(1'b0, 1);
               nop(1'b1, 3);
            end
            2: begin
               nop(1'b0, 3);
               u_ctrl.cyc(1'b1, CMD_ACT, 2'h1, 13'h0000);
               nop(1'b1, 2);
            end
            3: begin
               u_ctrl.cyc(1'b1, CMD_ACT, 2'h3, 13'h0000);
               nop(1'b1, 1);
               u_ctrl.cyc(1'b0, CMD_REF, 2'h0, 13'h0000);
               nop(1'b0, 3);
            end
            default: begin
               u_ctrl.cyc(1'b0, CMD_REF, 2'h0, 13'h0000);
               nop(1'b0, 2);
               nop(1'b1, 3);
               u_ctrl.cyc(1'b1, CMD_ACT, 2'h0, 13'h0000);
               u_ctrl.cyc(1'b1, CMD_RD, 2'h0, 13'h0000);
               nop(1'b1, 2);
            end
         endcase
         chk("illegal", 1'b1, illegal);
      end
      print_verdict();
   end
endmodule // cke_pwr_ctrl_bench
